// ===== inc/dpll_mode_status_params.svh
// Purpose: Register indices, field positions, reset values and codes for the
//          dual-loop mode and status register slice.
// Assumes: Included by its bare name from the design and the testbench.
// Notes:   Byte address of a register is four times its index.
`ifndef DPLL_MODE_STATUS_PARAMS_SVH
`define DPLL_MODE_STATUS_PARAMS_SVH

// ============================================================
// Register indices
`define IDX_LOOP1_STATE_FLAGS 6'h28
`define IDX_LOOP1_CAPTURE_SPAN 6'h29
`define IDX_LOOP2_CONTROL_A 6'h2a
`define IDX_LOOP2_CONTROL_B 6'h2b
`define IDX_LOOP2_OPERATING_MODE 6'h2c
`define IDX_LOOP2_REF_CHOICE 6'h2d
`define IDX_EVENT_STATUS 6'h31
`define IDX_EVENT_MASK 6'h32

// ============================================================
// Field positions
`define BIT_FLAG_HOLDOVER 0
`define BIT_FLAG_LOCK 1
`define BIT_FLAG_REF_FAIL 2
`define BIT_PHASE_ABSORB_CTRL 0
`define BIT_SLOPE_LIMIT_SEL 4
`define BIT_LOOP_ENABLE 7
`define BIT_REVERT_EN 0
`define BIT_EV_STATE_CHANGE 0
`define BIT_EV_REF_SWITCH 1
`define BIT_EV_LOOP1_REF_FAIL 2

// ============================================================
// Reset values
`define RST_CAPTURE_SPAN 2'h3
`define RST_CONTROL_A 8'h00
`define RST_CONTROL_B 8'h04
`define RST_OPERATING_MODE 2'h2
`define RST_REF_CHOICE 4'h0
`define RST_EVENT_MASK 3'h0

// ============================================================
// Mode codes and bus answers
`define MODE_MANUAL_NORMAL 2'h0
`define MODE_MANUAL_HOLDOVER 2'h1
`define MODE_MANUAL_FREERUN 2'h2
`define MODE_AUTO_NORMAL 2'h3
`define RESP_OKAY 2'h0
`define RESP_DECODEERROR 2'h3
`define DEFAULT_NUM_REFS 9

`endif

// ===== inc/dpll_mode_status_pkg.sv
// Purpose: Types shared by the dual-loop mode and status register slice.
// Assumes: Compiled before the design.
// Notes:   Numeric constants live in the params header.
package dpll_mode_status_pkg;
    // ============================================================
    // Second loop operating state
    typedef enum logic [1:0] {
        ST_DISABLED,
        ST_FREERUN,
        ST_HOLDOVER,
        ST_LOCKED
    } loop_state_t;
endpackage

// ===== logic/dpll_mode_status_regs.sv
// Purpose: Mode control and status registers of a dual digital loop timer,
//          with the second loop's reference and mode state machine.
// Assumes: All inputs synchronous to ref_clk; Avalon-MM slave with byte
//          addresses and one 8-bit register per aligned word.
// Notes:   Lower reference index means higher priority.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "dpll_mode_status_params.svh"

module dpll_mode_status_regs #(
    parameter int NUM_REFS = `DEFAULT_NUM_REFS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic [1:0] response,
    output logic waitrequest,
    // First loop status inputs
    input wire logic firstLoopHoldover,
    input wire logic firstLoopLocked,
    input wire logic firstLoopRefFail,
    // Reference monitor inputs, one bit per reference
    input wire logic [NUM_REFS-1:0] refQualified,
    input wire logic [NUM_REFS-1:0] refFailed,
    // First loop controls
    output logic [1:0] firstLoopCaptureSpan,
    // Second loop controls and state
    output logic secondLoopEnable,
    output logic phaseAbsorbCtrl,
    output logic slopeLimitSel,
    output logic revertEnable,
    output dpll_mode_status_pkg::loop_state_t secondLoopState,
    output logic [3:0] secondLoopActiveRef,
    output logic refSwitchStrobe,
    output logic switchAbsorbsPhase,
    // Interrupt
    output logic irq
);
    import dpll_mode_status_pkg::*;

    // Reference indices are four bits wide, so sixteen references at most.
    if (NUM_REFS < 1 || NUM_REFS > 16) begin : gen_bad_refs
        $error("NUM_REFS must lie between 1 and 16");
    end

    // ============================================================
    // Bus handshake
    logic ackQ, ackD;
    logic [31:0] readdataQ, readdataD;
    logic [1:0] responseQ, responseD;
    logic [5:0] regIdx;
    logic reqActive, wrTake, lowLane, mapped;

    // Every request waits one cycle, so read data always come from a flop.
    assign reqActive = read | write;
    assign waitrequest = reqActive & ~ackQ;
    assign wrTake = write & ackQ;
    assign regIdx = address[7:2];
    assign lowLane = byteenable[0];
    assign readdata = readdataQ;
    assign response = responseQ;

    // ============================================================
    // Register state
    logic [1:0] spanQ, spanD;
    logic absorbQ, absorbD, slopeQ, slopeD, enQ, enD, revertQ, revertD;
    logic [1:0] modeQ, modeD;
    logic [3:0] manualRefQ, manualRefD;
    logic [2:0] statusQ, statusD, maskQ, maskD, events;
    logic refFailPrevQ, refFailPrevD;

    // ============================================================
    // Second loop state
    loop_state_t stateQ, stateD;
    logic [3:0] activeQ, activeD;
    logic switchQ, switchD, autoQ, autoD;
    logic [NUM_REFS-1:0] refOk;
    logic anyOk, activeOk, manualOk, betterExists;
    logic [3:0] bestRef;

    // One usable flag per reference: qualified and not failing.
    genvar g;
    generate
        for (g = 0; g < NUM_REFS; g++) begin : gen_ok
            assign refOk[g] = refQualified[g] & ~refFailed[g];
        end
    endgenerate

    // Priority encoder picks the lowest usable index as the best reference.
    always_comb begin
        bestRef = 4'h0;
        for (int i = NUM_REFS - 1; i >= 0; i--) begin
            if (refOk[i]) begin
                bestRef = 4'(i);
            end
        end
    end

    // Manual choice is judged on failure alone; codes past the last
    // reference are reserved and count as a failed reference.
    assign anyOk = |refOk;
    assign activeOk = (32'(activeQ) < NUM_REFS) && refOk[activeQ];
    assign manualOk = (32'(manualRefQ) < NUM_REFS) && !refFailed[manualRefQ];
    assign betterExists = anyOk && (bestRef < activeQ);

    // Mode state machine of the second loop.
    always_comb begin
        stateD = stateQ;
        activeD = activeQ;
        autoD = enQ && (modeQ == `MODE_AUTO_NORMAL);
        if (!enQ) begin
            stateD = ST_DISABLED;
        end else begin
            case (modeQ)
                `MODE_MANUAL_NORMAL: begin
                    activeD = manualRefQ;
                    stateD = manualOk ? ST_LOCKED : ST_HOLDOVER;
                end
                `MODE_MANUAL_HOLDOVER: begin
                    stateD = ST_HOLDOVER;
                end
                `MODE_MANUAL_FREERUN: begin
                    stateD = ST_FREERUN;
                end
                `MODE_AUTO_NORMAL: begin
                    // Entry into automatic mode and revertive operation take the
                    // best; otherwise a healthy reference is kept over a better one.
                    if (autoQ && stateQ == ST_LOCKED && activeOk
                        && !(revertQ && betterExists)) begin
                        stateD = ST_LOCKED;
                    end else if (anyOk) begin
                        stateD = ST_LOCKED;
                        activeD = bestRef;
                    end else begin
                        stateD = ST_HOLDOVER;
                    end
                end
                default: begin
                    stateD = ST_FREERUN;
                end
            endcase
        end
        // A switch is only a change of reference while staying locked.
        switchD = (stateQ == ST_LOCKED) && (stateD == ST_LOCKED) && (activeD != activeQ);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stateQ <= ST_DISABLED;
            activeQ <= `RST_REF_CHOICE;
            switchQ <= 1'b0;
            autoQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            activeQ <= activeD;
            switchQ <= switchD;
            autoQ <= autoD;
        end
    end

    assign secondLoopState = stateQ;
    assign secondLoopActiveRef = activeQ;
    assign refSwitchStrobe = switchQ;
    assign switchAbsorbsPhase = ~absorbQ;
    assign firstLoopCaptureSpan = spanQ;
    assign secondLoopEnable = enQ;
    assign phaseAbsorbCtrl = absorbQ;
    assign slopeLimitSel = slopeQ;
    assign revertEnable = revertQ;

    // ============================================================
    // Register writes, read mux and sticky events
    always_comb begin
        ackD = reqActive & ~ackQ;
        readdataD = readdataQ;
        responseD = responseQ;
        spanD = spanQ;
        absorbD = absorbQ;
        slopeD = slopeQ;
        enD = enQ;
        revertD = revertQ;
        modeD = modeQ;
        manualRefD = manualRefQ;
        maskD = maskQ;
        refFailPrevD = firstLoopRefFail;
        events = 3'h0;
        events[`BIT_EV_STATE_CHANGE] = (stateD != stateQ);
        events[`BIT_EV_REF_SWITCH] = switchD;
        events[`BIT_EV_LOOP1_REF_FAIL] = firstLoopRefFail & ~refFailPrevQ;
        mapped = 1'b1;
        case (regIdx)
            `IDX_LOOP1_STATE_FLAGS, `IDX_LOOP1_CAPTURE_SPAN, `IDX_LOOP2_CONTROL_A,
            `IDX_LOOP2_CONTROL_B, `IDX_LOOP2_OPERATING_MODE, `IDX_LOOP2_REF_CHOICE,
            `IDX_EVENT_STATUS, `IDX_EVENT_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        // Capture read data in the waiting cycle; flags are sampled live
        // and reading clears nothing.
        if (reqActive && !ackQ) begin
            readdataD = 32'h0;
            responseD = mapped ? `RESP_OKAY : `RESP_DECODEERROR;
            if (read) begin
                case (regIdx)
                    `IDX_LOOP1_STATE_FLAGS: begin
                        readdataD[`BIT_FLAG_HOLDOVER] = firstLoopHoldover;
                        readdataD[`BIT_FLAG_LOCK] = firstLoopLocked;
                        readdataD[`BIT_FLAG_REF_FAIL] = firstLoopRefFail;
                    end
                    `IDX_LOOP1_CAPTURE_SPAN: readdataD[1:0] = spanQ;
                    `IDX_LOOP2_CONTROL_A: begin
                        readdataD[`BIT_PHASE_ABSORB_CTRL] = absorbQ;
                        readdataD[`BIT_SLOPE_LIMIT_SEL] = slopeQ;
                        readdataD[`BIT_LOOP_ENABLE] = enQ;
                    end
                    `IDX_LOOP2_CONTROL_B: begin
                        readdataD[7:0] = `RST_CONTROL_B;
                        readdataD[`BIT_REVERT_EN] = revertQ;
                    end
                    `IDX_LOOP2_OPERATING_MODE: readdataD[1:0] = modeQ;
                    `IDX_LOOP2_REF_CHOICE: begin
                        // Automatic mode reports the active reference.
                        readdataD[3:0] = (modeQ == `MODE_AUTO_NORMAL) ? activeQ : manualRefQ;
                    end
                    `IDX_EVENT_STATUS: readdataD[2:0] = statusQ;
                    `IDX_EVENT_MASK: readdataD[2:0] = maskQ;
                    default: readdataD = 32'h0;
                endcase
            end
        end
        // Writes land at the edge where waitrequest is low; only the low
        // byte lane holds register bits, reserved bits are not stored.
        if (wrTake && lowLane) begin
            case (regIdx)
                `IDX_LOOP1_CAPTURE_SPAN: spanD = writedata[1:0];
                `IDX_LOOP2_CONTROL_A: begin
                    absorbD = writedata[`BIT_PHASE_ABSORB_CTRL];
                    slopeD = writedata[`BIT_SLOPE_LIMIT_SEL];
                    enD = writedata[`BIT_LOOP_ENABLE];
                end
                `IDX_LOOP2_CONTROL_B: revertD = writedata[`BIT_REVERT_EN];
                `IDX_LOOP2_OPERATING_MODE: modeD = writedata[1:0];
                `IDX_LOOP2_REF_CHOICE: begin
                    if (modeQ == `MODE_MANUAL_NORMAL) begin
                        manualRefD = writedata[3:0];
                    end
                end
                `IDX_EVENT_MASK: maskD = writedata[2:0];
                default: manualRefD = manualRefD;
            endcase
        end
        // A new event beats a clear written in the same cycle.
        statusD = statusQ;
        if (wrTake && lowLane && regIdx == `IDX_EVENT_STATUS) begin
            statusD = statusQ & ~writedata[2:0];
        end
        statusD = statusD | events;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ackQ <= 1'b0;
            readdataQ <= 32'h0;
            responseQ <= `RESP_OKAY;
            spanQ <= `RST_CAPTURE_SPAN;
            absorbQ <= 1'(`RST_CONTROL_A >> `BIT_PHASE_ABSORB_CTRL);
            slopeQ <= 1'(`RST_CONTROL_A >> `BIT_SLOPE_LIMIT_SEL);
            enQ <= 1'(`RST_CONTROL_A >> `BIT_LOOP_ENABLE);
            revertQ <= 1'(`RST_CONTROL_B >> `BIT_REVERT_EN);
            modeQ <= `RST_OPERATING_MODE;
            manualRefQ <= `RST_REF_CHOICE;
            statusQ <= 3'h0;
            maskQ <= `RST_EVENT_MASK;
            refFailPrevQ <= 1'b0;
        end else begin
            ackQ <= ackD;
            readdataQ <= readdataD;
            responseQ <= responseD;
            spanQ <= spanD;
            absorbQ <= absorbD;
            slopeQ <= slopeD;
            enQ <= enD;
            revertQ <= revertD;
            modeQ <= modeD;
            manualRefQ <= manualRefD;
            statusQ <= statusD;
            maskQ <= maskD;
            refFailPrevQ <= refFailPrevD;
        end
    end

    assign irq = |(statusQ & maskQ);

    // ============================================================
    // Assertions
    logic readDone;
    assign readDone = read && !waitrequest;

    property p_flags_live;
        @(posedge ref_clk) disable iff (rst)
        (readDone && regIdx == `IDX_LOOP1_STATE_FLAGS) |->
            readdata[2:0] == {$past(firstLoopRefFail), $past(firstLoopLocked),
                              $past(firstLoopHoldover)};
    endproperty
    a_flags_live: assert property (p_flags_live) else $error("flag readback wrong");

    property p_flags_no_side;
        @(posedge ref_clk) disable iff (rst)
        (readDone && regIdx == `IDX_LOOP1_STATE_FLAGS) |=> ($past(statusQ) & ~statusQ) == 3'h0;
    endproperty
    a_flags_no_side: assert property (p_flags_no_side) else $error("read disturbed state");

    property p_span_reset;
        @(posedge ref_clk) $fell(rst) |-> firstLoopCaptureSpan == 2'h3 && !secondLoopEnable;
    endproperty
    a_span_reset: assert property (p_span_reset) else $error("bad reset values");

    property p_absorb;
        @(posedge ref_clk) disable iff (rst)
        refSwitchStrobe |-> switchAbsorbsPhase == !phaseAbsorbCtrl && secondLoopState == ST_LOCKED;
    endproperty
    a_absorb: assert property (p_absorb) else $error("switch phase style wrong");

    property p_disabled;
        @(posedge ref_clk) disable iff (rst)
        !secondLoopEnable |=> secondLoopState == ST_DISABLED;
    endproperty
    a_disabled: assert property (p_disabled) else $error("loop not disabled");

    property p_manual_track;
        @(posedge ref_clk) disable iff (rst)
        (enQ && modeQ == `MODE_MANUAL_NORMAL && manualOk) |=>
            secondLoopState == ST_LOCKED && secondLoopActiveRef == $past(manualRefQ);
    endproperty
    a_manual_track: assert property (p_manual_track) else $error("manual tracking wrong");

    property p_manual_fail;
        @(posedge ref_clk) disable iff (rst)
        (enQ && modeQ == `MODE_MANUAL_NORMAL && !manualOk) |=> secondLoopState == ST_HOLDOVER;
    endproperty
    a_manual_fail: assert property (p_manual_fail) else $error("no holdover on failure");

    property p_fixed_modes;
        @(posedge ref_clk) disable iff (rst)
        (enQ && modeQ[1] != modeQ[0]) |=>
            secondLoopState == ($past(modeQ) == `MODE_MANUAL_HOLDOVER ? ST_HOLDOVER : ST_FREERUN);
    endproperty
    a_fixed_modes: assert property (p_fixed_modes) else $error("fixed mode state wrong");

    property p_auto_none;
        @(posedge ref_clk) disable iff (rst)
        (enQ && modeQ == `MODE_AUTO_NORMAL && !anyOk) |=> secondLoopState == ST_HOLDOVER;
    endproperty
    a_auto_none: assert property (p_auto_none) else $error("no holdover without refs");

    property p_auto_switch;
        @(posedge ref_clk) disable iff (rst)
        (enQ && modeQ == `MODE_AUTO_NORMAL && stateQ == ST_LOCKED && !activeOk && anyOk) |=>
            secondLoopState == ST_LOCKED && secondLoopActiveRef == $past(bestRef) && refSwitchStrobe;
    endproperty
    a_auto_switch: assert property (p_auto_switch) else $error("switchover wrong");

    property p_choice_read;
        @(posedge ref_clk) disable iff (rst)
        (readDone && regIdx == `IDX_LOOP2_REF_CHOICE && modeQ == `MODE_AUTO_NORMAL
         && $stable(activeQ)) |-> readdata[3:0] == activeQ;
    endproperty
    a_choice_read: assert property (p_choice_read) else $error("choice readback wrong");

    c_auto_switch: cover property (@(posedge ref_clk) disable iff (rst)
        modeQ == `MODE_AUTO_NORMAL ##0 refSwitchStrobe);
    c_manual_hold: cover property (@(posedge ref_clk) disable iff (rst)
        modeQ == `MODE_MANUAL_NORMAL && stateQ == ST_LOCKED ##1 stateQ == ST_HOLDOVER);
    c_irq: cover property (@(posedge ref_clk) disable iff (rst) $rose(irq));
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the dual-loop mode and status registers.
// Assumes: One clock, Avalon-MM master tasks, inputs driven on rising edges.
// Notes:   Reset table first, then hand-written mode, switch and interrupt cases.
`timescale 1ns/1ps
`include "dpll_mode_status_params.svh"

// Count a comparison and report a mismatch at once.
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
    import dpll_mode_status_pkg::*;
    // ============================================================
    // Signals
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [1:0] response;
    logic waitrequest;
    logic firstLoopHoldover = 1'b0;
    logic firstLoopLocked = 1'b0;
    logic firstLoopRefFail = 1'b0;
    logic [8:0] refQualified = 9'h1ff;
    logic [8:0] refFailed = 9'h000;
    logic [1:0] firstLoopCaptureSpan;
    logic secondLoopEnable, phaseAbsorbCtrl, slopeLimitSel, revertEnable;
    loop_state_t secondLoopState;
    logic [3:0] secondLoopActiveRef;
    logic refSwitchStrobe, switchAbsorbsPhase, irq;
    int errors = 0;
    int nCompared = 0;
    int nSwitch = 0;
    int i;
    logic [31:0] rd;
    logic [1:0] rsp;
    // Reset values by byte address, with the last row an unmapped index.
    row_t rows [6] = '{'{8'ha4, 32'h03, 2'h0}, '{8'ha8, 32'h00, 2'h0},
        '{8'hac, 32'h04, 2'h0}, '{8'hb0, 32'h02, 2'h0}, '{8'hb4, 32'h00, 2'h0},
        '{8'hfc, 32'h00, 2'h3}};

    // Free-running 50 MHz clock.
    always #10 ref_clk = ~ref_clk;

    // Count reference switch pulses, each high for one cycle.
    always @(posedge ref_clk) begin
        if (refSwitchStrobe === 1'b1) begin
            nSwitch++;
        end
    end

    dpll_mode_status_regs #(.NUM_REFS(9)) u_dpll_mode_status_regs (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .response(response), .waitrequest(waitrequest),
        .firstLoopHoldover(firstLoopHoldover), .firstLoopLocked(firstLoopLocked),
        .firstLoopRefFail(firstLoopRefFail), .refQualified(refQualified),
        .refFailed(refFailed), .firstLoopCaptureSpan(firstLoopCaptureSpan),
        .secondLoopEnable(secondLoopEnable), .phaseAbsorbCtrl(phaseAbsorbCtrl),
        .slopeLimitSel(slopeLimitSel), .revertEnable(revertEnable),
        .secondLoopState(secondLoopState), .secondLoopActiveRef(secondLoopActiveRef),
        .refSwitchStrobe(refSwitchStrobe), .switchAbsorbsPhase(switchAbsorbsPhase),
        .irq(irq));

    // ============================================================
    // Tasks
    // Final report; the only place the run ends.
    task automatic end_sim;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One bus cycle, held until waitrequest is seen low at a rising edge.
    // The answer is taken at that edge, before the design's flops move on it.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        address <= a;
        writedata <= {24'h0, d};
        read <= !wr;
        write <= wr;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            errors++;
            end_sim();
        end
        rd = readdata;
        rsp = response;
        read <= 1'b0;
        write <= 1'b0;
        // Callers look at outputs mid-cycle, once the landing edge has settled.
        @(negedge ref_clk);
    endtask

    // Read a register and compare its low byte, upper bits zero.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask

    // Let the loop state follow a change, then look where outputs are settled.
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values and the decode error answer from one table.
        for (i = 0; i < 6; i++) begin
            bus(1'b0, rows[i].a, 8'h00);
            `CHK(rd, rows[i].d)
            `CHK(rsp, rows[i].r)
        end
        `CHK(firstLoopCaptureSpan, 2'h3)
        `CHK(secondLoopState, ST_DISABLED)
        $display("test reset_table done");
        // Every flag pattern, read twice to show reads leave flags alone.
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            {firstLoopRefFail, firstLoopLocked, firstLoopHoldover} <= i[2:0];
            repeat (2) begin
                bus(1'b0, 8'ha0, 8'h00);
                `CHK(rd[2:0], i[2:0])
            end
        end
        $display("test flags done");
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 8'ha4, i[7:0]);
            rdchk(8'ha4, i[7:0]);
            `CHK(firstLoopCaptureSpan, i[1:0])
        end
        // A write without the low byte lane must not land.
        @(posedge ref_clk);
        byteenable <= 4'h0;
        bus(1'b1, 8'ha4, 8'h00);
        @(posedge ref_clk);
        byteenable <= 4'h1;
        rdchk(8'ha4, 8'h03);
        $display("test capture_span done");
        bus(1'b1, 8'ha8, 8'h91);
        rdchk(8'ha8, 8'h91);
        `CHK({secondLoopEnable, slopeLimitSel, phaseAbsorbCtrl, switchAbsorbsPhase}, 4'he)
        bus(1'b1, 8'ha8, 8'h80);
        `CHK({secondLoopEnable, slopeLimitSel, phaseAbsorbCtrl, switchAbsorbsPhase}, 4'h9)
        bus(1'b1, 8'hac, 8'h05);
        `CHK(revertEnable, 1'b1)
        bus(1'b1, 8'hac, 8'h04);
        `CHK(revertEnable, 1'b0)
        $display("test controls done");
        settle();
        `CHK(secondLoopState, ST_FREERUN)
        bus(1'b1, 8'hb0, 8'h01);
        settle();
        `CHK(secondLoopState, ST_HOLDOVER)
        bus(1'b1, 8'hb0, 8'h00);
        bus(1'b1, 8'hb4, 8'h03);
        settle();
        `CHK({secondLoopState, secondLoopActiveRef}, {ST_LOCKED, 4'h3})
        rdchk(8'hb4, 8'h03);
        @(posedge ref_clk);
        refFailed <= 9'h008;
        settle();
        `CHK(secondLoopState, ST_HOLDOVER)
        @(posedge ref_clk);
        refFailed <= 9'h000;
        bus(1'b1, 8'hb0, 8'h03);
        settle();
        `CHK({secondLoopState, secondLoopActiveRef}, {ST_LOCKED, 4'h0})
        bus(1'b1, 8'hb4, 8'h07);
        rdchk(8'hb4, 8'h00);
        @(posedge ref_clk);
        refFailed <= 9'h001;
        settle();
        `CHK({secondLoopState, secondLoopActiveRef}, {ST_LOCKED, 4'h1})
        // Healed best reference is kept away until revertive mode is on.
        @(posedge ref_clk);
        refFailed <= 9'h000;
        settle();
        `CHK(secondLoopActiveRef, 4'h1)
        bus(1'b1, 8'hac, 8'h05);
        settle();
        `CHK(secondLoopActiveRef, 4'h0)
        @(posedge ref_clk);
        refFailed <= 9'h1ff;
        settle();
        `CHK(secondLoopState, ST_HOLDOVER)
        $display("test modes done");
        // Events so far: state changes, four reference switches, a flag rise.
        bus(1'b1, 8'hc8, 8'h07);
        rdchk(8'hc8, 8'h07);
        rdchk(8'hc4, 8'h07);
        `CHK(irq, 1'b1)
        bus(1'b1, 8'hc4, 8'h07);
        rdchk(8'hc4, 8'h00);
        `CHK(irq, 1'b0)
        bus(1'b1, 8'hc8, 8'h02);
        @(posedge ref_clk);
        refFailed <= 9'h1fd;
        settle();
        `CHK({irq, secondLoopActiveRef}, {1'b0, 4'h1})
        rdchk(8'hc4, 8'h01);
        bus(1'b1, 8'hc8, 8'h01);
        @(negedge ref_clk);
        `CHK(irq, 1'b1)
        bus(1'b1, 8'hc4, 8'h01);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        // A reference that is not qualified is not usable in automatic mode.
        @(posedge ref_clk);
        refQualified <= 9'h1fd;
        settle();
        `CHK(secondLoopState, ST_HOLDOVER)
        `CHK(nSwitch, 4)
        $display("test interrupts done");
        end_sim();
    end
endmodule
